//--- verilog/eprc_top.sv
// Decided for this implementation: the Wishbone register port.
`include "eprc_defines.svh"
module eprc_top
  import eprc_pkg::*;
#(
  parameter int unsigned FILT_CYC = `EPRC_FILT_CYC,
  parameter int unsigned P1_CYC = `EPRC_P1_CYC,
  parameter int unsigned P5_CYC = `EPRC_P5_CYC,
  parameter int unsigned P100_CYC = `EPRC_P100_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic enable_pin_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic forced_halt_signal_o,
  output logic control_clear_signal_o,
  output logic core_init_signal_o,
  output logic clock_stopped_o,
  output logic display_run_o,
  output logic pll_run_o,
  output logic osc_sense_pulldown_o,
  output logic phase_error_oe_o,
  output logic prescaler_mode_output_o,
  output logic crystal_in_pulldown_o,
  output logic crystal_out_o,
  output logic display_aux_oe_o,
  output logic port_io_force_input_o,
  output logic port_in_pulldown_o,
  output logic port_out_hold_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic [31:0] fcnt;
    logic rise_flag;
    logic pll_off;
    logic osd_en;
    logic [1:0] sel;
    logic [31:0] tcnt;
    logic carry;
    eprc_state_t st;
    logic pend;
    logic halt;
    logic clr;
    logic init;
    logic ack;
    logic [31:0] dat;
  } eprc_regs_t;

  eprc_regs_t state_reg, state_next;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] period_of(input logic [1:0] s);
    case (s)
      2'h1: period_of = P5_CYC;
      2'h2: period_of = P100_CYC;
      default: period_of = P1_CYC;
    endcase
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  // ****************************************
  // pll gating, shared by three pins
  // ****************************************
  function automatic logic pll_on(input eprc_regs_t r);
    pll_on = r.level && !r.pll_off && (r.st != EPRC_STOP);
  endfunction

  logic wb_req;
  logic stopped;
  assign wb_req = wb_cyc_i && wb_stb_i && !state_reg.ack;
  assign stopped = (state_reg.st == EPRC_STOP);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_next = state_reg;
    // pin synchroniser; only s2/s3 are compared
    state_next.s1 = enable_pin_i;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    // deglitch counter
    if (state_reg.s2 == state_reg.s3 && state_reg.s3 != state_reg.level) begin
      if (state_reg.fcnt >= FILT_CYC - 1) begin
        state_next.level = state_reg.s3;
        state_next.fcnt = 32'h0;
      end else begin
        state_next.fcnt = state_reg.fcnt + 32'h1;
      end
    end else begin
      state_next.fcnt = 32'h0;
    end
    // basic timer carry pulse, runs unless clock stopped
    state_next.carry = 1'b0;
    if (!stopped) begin
      if (state_reg.tcnt >= period_of(state_reg.sel) - 1) begin
        state_next.tcnt = 32'h0;
        state_next.carry = 1'b1;
      end else begin
        state_next.tcnt = state_reg.tcnt + 32'h1;
      end
    end
    // bus
    state_next.ack = 1'b0;
    if (wb_req) begin
      state_next.ack = 1'b1;
      state_next.dat = 32'h0;
      if (hit(wb_adr_i, `EPRC_ADDR_EDGE) && !wb_we_i) begin
        state_next.dat[`EPRC_BIT_FLAG] = state_reg.rise_flag;
        state_next.rise_flag = 1'b0;
      end else if (hit(wb_adr_i, `EPRC_ADDR_LEVEL)) begin
        state_next.dat[`EPRC_BIT_FLAG] = state_reg.level;
      end else if (hit(wb_adr_i, `EPRC_ADDR_CTRL)) begin
        if (wb_we_i && wb_sel_i[0]) begin
          state_next.pll_off = wb_dat_i[`EPRC_BIT_PLLOFF];
          state_next.osd_en = wb_dat_i[`EPRC_BIT_OSDEN];
          state_next.sel = wb_dat_i[`EPRC_SEL_LSB+:2];
        end
        state_next.dat[`EPRC_BIT_PLLOFF] = state_reg.pll_off;
        state_next.dat[`EPRC_BIT_OSDEN] = state_reg.osd_en;
        state_next.dat[`EPRC_SEL_LSB+:2] = state_reg.sel;
      end else if (hit(wb_adr_i, `EPRC_ADDR_STAT)) begin
        state_next.dat[2:0] = state_reg.st;
        state_next.dat[3] = state_reg.halt;
        state_next.dat[4] = state_reg.pend;
      end else if (hit(wb_adr_i, `EPRC_ADDR_CMD) && wb_we_i && wb_sel_i[0]) begin
        if (wb_dat_i[`EPRC_CMD_POR]) begin
          // software-modelled power-on reset
          state_next.halt = 1'b1;
          state_next.clr = 1'b1;
          state_next.init = 1'b1;
          state_next.sel = 2'h2;
          state_next.pll_off = 1'b0;
          state_next.osd_en = 1'b0;
          state_next.tcnt = 32'h0;
          state_next.st = EPRC_WAIT;
        end else if (wb_dat_i[`EPRC_CMD_HALT] && !state_reg.level) begin
          // valid clock-halt: enter stop
          state_next.st = EPRC_STOP;
          state_next.halt = 1'b1;
          state_next.clr = 1'b1;
          state_next.init = 1'b1;
          state_next.sel = 2'h2;
          state_next.pll_off = 1'b0;
          state_next.osd_en = 1'b0;
          state_next.tcnt = 32'h0;
        end
      end
    end
    // filtered rising edge: set wins over read clear
    if (state_reg.level == 1'b0 && state_next.level == 1'b1) begin
      state_next.rise_flag = 1'b1;
      if (stopped) begin
        state_next.st = EPRC_WAIT;
        // timer count starts mid period: release half a period later
        state_next.tcnt = P100_CYC / 2;
      end else begin
        state_next.pend = 1'b1;
        state_next.init = 1'b1;
      end
    end
    // release on carry pulse
    case (state_reg.st)
      EPRC_RUN: begin
        if (state_reg.pend && state_reg.carry) begin
          state_next.pend = 1'b0;
          state_next.init = 1'b0;
        end
      end
      EPRC_WAIT: begin
        if (state_reg.carry) begin
          state_next.st = EPRC_RUN;
          state_next.halt = 1'b0;
          state_next.clr = 1'b0;
          state_next.init = 1'b0;
          state_next.pend = 1'b0;
        end
      end
      EPRC_STOP: begin
      end
      default: begin
        state_next.st = EPRC_RUN;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
      state_reg.sel <= 2'h2;
      state_reg.st <= EPRC_WAIT;
      state_reg.halt <= 1'b1;
      state_reg.clr <= 1'b1;
      state_reg.init <= 1'b1;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
      wb_ack_o <= 1'b0;
      forced_halt_signal_o <= 1'b1;
      control_clear_signal_o <= 1'b1;
      core_init_signal_o <= 1'b1;
      clock_stopped_o <= 1'b0;
      display_run_o <= 1'b0;
      pll_run_o <= 1'b0;
      osc_sense_pulldown_o <= 1'b1;
      phase_error_oe_o <= 1'b0;
      prescaler_mode_output_o <= 1'b0;
      crystal_in_pulldown_o <= 1'b0;
      crystal_out_o <= 1'b0;
      display_aux_oe_o <= 1'b0;
      port_io_force_input_o <= 1'b0;
      port_in_pulldown_o <= 1'b0;
      port_out_hold_o <= 1'b0;
    end else if (ce_i) begin
      wb_dat_o <= state_next.dat;
      wb_ack_o <= state_next.ack;
      forced_halt_signal_o <= state_next.halt;
      control_clear_signal_o <= state_next.clr;
      core_init_signal_o <= state_next.init;
      clock_stopped_o <= state_next.st == EPRC_STOP;
      display_run_o <= state_next.level && state_next.osd_en;
      pll_run_o <= pll_on(state_next);
      osc_sense_pulldown_o <= !state_next.level
        || state_next.st == EPRC_STOP;
      phase_error_oe_o <= pll_on(state_next);
      prescaler_mode_output_o <= pll_on(state_next);
      crystal_in_pulldown_o <= state_next.st == EPRC_STOP;
      crystal_out_o <= state_next.st == EPRC_STOP;
      display_aux_oe_o <= state_next.st != EPRC_STOP
        && state_next.level && state_next.osd_en;
      port_io_force_input_o <= state_next.st == EPRC_STOP;
      port_in_pulldown_o <= state_next.st == EPRC_STOP;
      port_out_hold_o <= state_next.st == EPRC_STOP;
    end
  end
endmodule

//--- verilog/eprc_defines.svh
`ifndef EPRC_DEFINES_SVH
`define EPRC_DEFINES_SVH
// ****************************************
// register map
// ****************************************
`define EPRC_ADDR_EDGE 8'h02
`define EPRC_ADDR_LEVEL 8'h07
`define EPRC_ADDR_CTRL 8'h10
`define EPRC_ADDR_STAT 8'h11
`define EPRC_ADDR_CMD 8'h12
`define EPRC_EDGE_RST 4'h0
`define EPRC_CTRL_RST 4'h0
`define EPRC_BIT_FLAG 0
`define EPRC_BIT_PLLOFF 0
`define EPRC_BIT_OSDEN 1
`define EPRC_SEL_LSB 2
`define EPRC_CMD_HALT 0
`define EPRC_CMD_POR 1
// ****************************************
// timing
// ****************************************
`define EPRC_CLK_MHZ 125
`define EPRC_FILT_MIN_US 110
`define EPRC_FILT_MAX_US 165
// stable interval taken midway in the window
`define EPRC_FILT_US 137
`define EPRC_FILT_CYC (`EPRC_FILT_US * `EPRC_CLK_MHZ)
`define EPRC_P1_MS 1
`define EPRC_P5_MS 5
`define EPRC_P100_MS 100
`define EPRC_P1_CYC (`EPRC_P1_MS * 1000 * `EPRC_CLK_MHZ)
`define EPRC_P5_CYC (`EPRC_P5_MS * 1000 * `EPRC_CLK_MHZ)
`define EPRC_P100_CYC (`EPRC_P100_MS * 1000 * `EPRC_CLK_MHZ)
`endif

//--- verilog/eprc_pkg.sv
package eprc_pkg;
  typedef enum logic [2:0] {
    EPRC_RUN = 3'h1,
    EPRC_WAIT = 3'h2,
    EPRC_STOP = 3'h4
  } eprc_state_t;
endpackage

//--- testbench/eprc_top_properties.sv
// ****************
// checker
// ****************
module eprc_top_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_ack_o,
  input wire logic forced_halt_signal_o,
  input wire logic control_clear_signal_o,
  input wire logic core_init_signal_o,
  input wire logic clock_stopped_o,
  input wire logic display_run_o,
  input wire logic pll_run_o,
  input wire logic osc_sense_pulldown_o,
  input wire logic phase_error_oe_o,
  input wire logic prescaler_mode_output_o,
  input wire logic crystal_in_pulldown_o,
  input wire logic crystal_out_o,
  input wire logic display_aux_oe_o,
  input wire logic port_io_force_input_o,
  input wire logic port_in_pulldown_o,
  input wire logic port_out_hold_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  chk_pll_sense: assert property (pll_run_o |->
    !osc_sense_pulldown_o && phase_error_oe_o) else $error("pll pins");
  chk_psc_low: assert property (!pll_run_o |->
    !prescaler_mode_output_o) else $error("prescaler not low");
  chk_stop_xtal: assert property (clock_stopped_o |->
    crystal_in_pulldown_o && crystal_out_o) else $error("crystal pins");
  chk_stop_inputs: assert property (clock_stopped_o |->
    port_io_force_input_o && port_in_pulldown_o) else $error("io pins");
  chk_stop_hold: assert property (clock_stopped_o |->
    port_out_hold_o) else $error("outputs not held");
  chk_stop_aux: assert property (clock_stopped_o |->
    !display_aux_oe_o && !display_run_o) else $error("aux pin");
  chk_stop_resets: assert property ($rose(clock_stopped_o) |->
    forced_halt_signal_o && control_clear_signal_o && core_init_signal_o)
    else $error("stop resets missing");
  chk_halt_init: assert property (forced_halt_signal_o |->
    core_init_signal_o) else $error("halt without init");
endmodule
bind eprc_top eprc_top_properties u_eprc_top_properties (.*);

//--- testbench/eprc_pin_host.sv
// ****************
// host pin driver
// ****************
module eprc_pin_host (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic level_i,
  input wire logic [7:0] len_i,
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_reg = 8'h00;
  initial pin_o = 1'h0;
  // len 0 holds the level, else a pulse of len cycles
  always @(posedge clk_i) begin
    if (go_i) begin
      pin_o <= level_i;
      cnt_reg <= len_i;
    end else if (cnt_reg == 8'h01) begin
      pin_o <= !pin_o;
      cnt_reg <= 8'h00;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end
endmodule

//--- testbench/tb_eprc_top.sv
// ****************
// testbench
// ****************
module tb_eprc_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1, wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0, wb_we_i = 1'h0, go = 1'h0, lvl = 1'h0;
  logic enable_pin_i, wb_ack_o, forced_halt_signal_o;
  logic [7:0] wb_adr_i = 8'h00, len = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic control_clear_signal_o, core_init_signal_o, clock_stopped_o;
  logic display_run_o, pll_run_o, osc_sense_pulldown_o, phase_error_oe_o;
  logic prescaler_mode_output_o, crystal_in_pulldown_o, crystal_out_o;
  logic display_aux_oe_o, port_io_force_input_o, port_in_pulldown_o;
  logic port_out_hold_o;
  int bad_count = 0, cmp_count = 0;
  eprc_top #(.FILT_CYC(8), .P1_CYC(20), .P5_CYC(40), .P100_CYC(80))
    u_eprc_top (.*);
  eprc_pin_host u_eprc_pin_host (.clk_i(clk_i), .go_i(go), .level_i(lvl),
    .len_i(len), .pin_o(enable_pin_i));
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 50);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    if (n >= 50) begin
      bad_count++;
      end_sim;
    end
  endtask
  task automatic pin(input logic l, input logic [7:0] n);
    @(posedge clk_i);
    {go, lvl, len} <= {1'h1, l, n};
    @(posedge clk_i);
    go <= 1'h0;
  endtask
  task automatic s_regs;
    wb(0, 8'h02, 0); chk("edge", q, 32'h0);
    wb(0, 8'h07, 0); chk("level", q, 32'h0);
    wb(0, 8'h10, 0); chk("ctrl", q, 32'h8);
    wb(1, 8'h30, 32'hF); wb(0, 8'h30, 0); chk("unmapped", q, 32'h0);
    pin(1, 8'h04); wt(30);
    wb(0, 8'h07, 0); chk("glitch level", q, 32'h0);
    wb(0, 8'h02, 0); chk("glitch edge", q, 32'h0);
  endtask
  task automatic s_rise;
    logic seen = 1'h0;
    logic h = 1'h1;
    pin(1, 8'h00);
    repeat (30) begin
      @(posedge clk_i);
      if (!seen && core_init_signal_o === 1'h1) begin
        seen = 1'h1;
        h = forced_halt_signal_o;
      end
    end
    chk("init on rise", seen, 32'h1);
    chk("no halt on rise", h, 32'h0);
    wb(0, 8'h07, 0); chk("level high", q, 32'h1);
    wb(0, 8'h02, 0); chk("edge set", q, 32'h1);
    wb(0, 8'h02, 0); chk("edge clear", q, 32'h0);
    pin(0, 8'h04); wt(30);
    wb(0, 8'h07, 0); chk("low glitch", q, 32'h1);
    wt(80); chk("init release", core_init_signal_o, 32'h0);
  endtask
  task automatic s_pll;
    wb(1, 8'h10, 32'hA); wt(3);
    chk("pll on", pll_run_o, 32'h1);
    chk("display on", display_run_o, 32'h1);
    wb(1, 8'h10, 32'hB); wt(3);
    chk("pll off", pll_run_o, 32'h0);
    chk("psc", prescaler_mode_output_o, 32'h0);
  endtask
  task automatic s_halt;
    wb(1, 8'h12, 32'h1); wt(3);
    chk("stop ignored", clock_stopped_o, 32'h0);
    pin(0, 8'h00); wt(30);
    chk("display low", display_run_o, 32'h0);
    chk("sense pull", osc_sense_pulldown_o, 32'h1);
    wb(1, 8'h12, 32'h1); wt(3);
    chk("stopped", clock_stopped_o, 32'h1);
    chk("clear", control_clear_signal_o, 32'h1);
    chk("crystal_out", crystal_out_o, 32'h1);
    pin(1, 8'h00); wt(25);
    chk("halt held", forced_halt_signal_o, 32'h1);
    wt(35); chk("halt off", forced_halt_signal_o, 32'h0);
    wb(0, 8'h10, 0); chk("sel 100", q, 32'h8);
  endtask
  task automatic s_por;
    wb(1, 8'h12, 32'h2); wt(3);
    chk("por halt", forced_halt_signal_o, 32'h1);
    chk("por clear", control_clear_signal_o, 32'h1);
    wt(100); chk("por done", core_init_signal_o, 32'h0);
  endtask
  task automatic s_ce;
    @(posedge clk_i);
    ce_i <= 1'h0;
    pin(0, 8'h00); wt(30);
    chk("frozen sense", osc_sense_pulldown_o, 32'h0);
    ce_i <= 1'h1;
    wt(30);
    chk("thawed sense", osc_sense_pulldown_o, 32'h1);
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    wt(4);
    rst_i <= 1'h0;
    wt(100);
    s_regs;
    s_rise;
    s_pll;
    s_halt;
    s_por;
    s_ce;
    end_sim;
  end
  initial begin
    wt(4000);
    bad_count++;
    end_sim;
  end
endmodule
